// ---- pwm_cap_pkg.sv ----
package pwm_cap_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] PER_OFF   = 8'h00;
  localparam logic [7:0] MODE_OFF  = 8'h04;
  localparam logic [7:0] TRIG_OFF  = 8'h08;
  localparam logic [7:0] EN_OFF    = 8'h0c;
  localparam logic [7:0] CNT_OFF   = 8'h10;
  localparam logic [7:0] DATA_OFF  = 8'h14;
  localparam logic [7:0] STAT_OFF  = 8'h18;
  localparam logic [7:0] IRQS_OFF  = 8'h1c;
  localparam logic [7:0] IRQM_OFF  = 8'h20;
  localparam logic [7:0] OUTC_OFF  = 8'h24;

  // ***************************************************************
  // field positions and codes
  // ***************************************************************
  localparam int UNIT_EN_BIT   = 0;
  localparam int START_BIT     = 0;
  localparam int STOP_BIT      = 1;
  localparam int OVF_BIT       = 0;
  localparam int NF_BIT        = 0;
  localparam int EDGE_LO       = 8;
  localparam int EDGE_HI       = 9;
  localparam logic [1:0] EDGE_LOW_WIDTH  = 2'h2;
  localparam logic [1:0] EDGE_HIGH_WIDTH = 2'h3;
  localparam int IRQ_CAPT_BIT  = 0;
  localparam int CNT_W         = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_WAIT_START,
    CH_COUNT
  } ch_state_t;

endpackage : pwm_cap_pkg

// ---- pin_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // pin
  input  wire logic pin_in,
  // edges
  output logic      rise_o,
  output logic      fall_o
);

  logic pin_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_in;
    end
  end

  assign rise_o = pin_in & ~pin_q;
  assign fall_o = ~pin_in & pin_q;

endmodule : pin_edge_detect

`default_nettype wire

// ---- width_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

module width_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // control
  input  wire logic         clear_i,
  input  wire logic         clr_all_i,
  input  wire logic         run_i,
  // state
  output logic [W-1:0]      count_o,
  output logic              wrapped_o
);

  // ***************************************************************
  // up counter, wraps at max
  // ***************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_o   <= '0;
      wrapped_o <= 1'b0;
    end else if (clr_all_i || clear_i) begin
      count_o   <= '0;
      wrapped_o <= 1'b0;
    end else if (run_i) begin
      count_o <= count_o + 1'b1;
      if (&count_o) begin
        wrapped_o <= 1'b1;
      end
    end
  end

endmodule : width_counter

`default_nettype wire

// ---- pulse_width_capture_channel.sv ----
// Overview of operation
// - start trigger sets enable status and waits for start edge.
// - start edge clears count to zero, then counts up.
// - capture edge copies count to data register, raises interrupt.
// - each capture sets overflow if counter wrapped, else clears it.
// - after capture counting halts until next start edge; repeats.
// - stop trigger clears enable status and stops; triggers self-clear.
// - when stopped, count and overflow flag hold their values.
// - data, count and status registers readable while unit clock enabled; read as zero when it is clear.
// - clearing unit clock enable stops unit, initializes registers.
// - edge select 10 measures low width, 11 high width.
// - start trigger ignored while enable status already set.
`timescale 1ns/1ps
`default_nettype none

module pulse_width_capture_channel #(
  parameter int CNT_W = pwm_cap_pkg::CNT_W
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pin and interrupt
  input  wire logic        timer_input_pin,
  output logic             irq_o
);

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic        req;
  logic        wr;
  logic [31:0] wmask;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // ***************************************************************
  // registers
  // ***************************************************************
  logic             unit_clock_enable_q;
  logic [1:0]       edge_sel_q;
  logic             noise_filter_enable_q;
  logic [2:0]       out_ctrl_q;
  logic             channel_enable_status_q;
  logic [CNT_W-1:0] capture_data_q;
  logic             counter_overflow_flag_q;
  logic             irq_stat_q;
  logic             irq_mask_q;
  logic             unit_on;

  assign unit_on = unit_clock_enable_q;

  // unit clock enable, always writable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      unit_clock_enable_q <= 1'b0;
    end else if (wr && wb_adr_i == pwm_cap_pkg::PER_OFF && wb_sel_i[0]) begin
      unit_clock_enable_q <= wb_dat_i[pwm_cap_pkg::UNIT_EN_BIT];
    end
  end

  // mode, filter and output control; init when unit off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_sel_q            <= pwm_cap_pkg::EDGE_HIGH_WIDTH;
      noise_filter_enable_q <= 1'b0;
      out_ctrl_q            <= 3'h0;
    end else if (!unit_on) begin
      edge_sel_q            <= pwm_cap_pkg::EDGE_HIGH_WIDTH;
      noise_filter_enable_q <= 1'b0;
      out_ctrl_q            <= 3'h0;
    end else if (wr) begin
      if (wb_adr_i == pwm_cap_pkg::MODE_OFF) begin
        if (wb_sel_i[0]) begin
          noise_filter_enable_q <= wb_dat_i[pwm_cap_pkg::NF_BIT];
        end
        if (wb_sel_i[1]) begin
          edge_sel_q <= wb_dat_i[pwm_cap_pkg::EDGE_HI:pwm_cap_pkg::EDGE_LO];
        end
      end
      if (wb_adr_i == pwm_cap_pkg::OUTC_OFF && wb_sel_i[0]) begin
        out_ctrl_q <= wb_dat_i[2:0];
      end
    end
  end

  // ***************************************************************
  // pin edges and measurement polarity
  // ***************************************************************
  logic rise;
  logic fall;
  logic start_edge;
  logic capt_edge;
  logic measure_high;

  pin_edge_detect u_edge (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_in   (timer_input_pin),
    .rise_o   (rise),
    .fall_o   (fall)
  );

  // high width: rise starts, fall captures; low width the reverse
  assign measure_high = (edge_sel_q == pwm_cap_pkg::EDGE_HIGH_WIDTH);
  assign start_edge   = measure_high ? rise : fall;
  assign capt_edge    = measure_high ? fall : rise;

  // ***************************************************************
  // triggers and channel state
  // ***************************************************************
  logic start_trig;
  logic stop_trig;
  pwm_cap_pkg::ch_state_t state_q;

  // trigger bits are pulses only; nothing is stored
  assign start_trig = unit_on & wr & (wb_adr_i == pwm_cap_pkg::TRIG_OFF)
                    & wb_sel_i[0] & wb_dat_i[pwm_cap_pkg::START_BIT];
  assign stop_trig  = unit_on & wr & (wb_adr_i == pwm_cap_pkg::TRIG_OFF)
                    & wb_sel_i[0] & wb_dat_i[pwm_cap_pkg::STOP_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q                 <= pwm_cap_pkg::CH_IDLE;
      channel_enable_status_q <= 1'b0;
    end else if (!unit_on) begin
      state_q                 <= pwm_cap_pkg::CH_IDLE;
      channel_enable_status_q <= 1'b0;
    end else if (stop_trig) begin
      state_q                 <= pwm_cap_pkg::CH_IDLE;
      channel_enable_status_q <= 1'b0;
    end else begin
      unique case (state_q)
        pwm_cap_pkg::CH_IDLE: begin
          if (start_trig && !channel_enable_status_q) begin
            state_q                 <= pwm_cap_pkg::CH_WAIT_START;
            channel_enable_status_q <= 1'b1;
          end
        end
        pwm_cap_pkg::CH_WAIT_START: begin
          if (start_edge) begin
            state_q <= pwm_cap_pkg::CH_COUNT;
          end
        end
        pwm_cap_pkg::CH_COUNT: begin
          if (capt_edge) begin
            state_q <= pwm_cap_pkg::CH_WAIT_START;
          end
        end
        default: begin
          state_q <= pwm_cap_pkg::CH_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // counter
  // ***************************************************************
  logic [CNT_W-1:0] count;
  logic             wrapped;
  logic             counting;
  logic             do_start;
  logic             do_capture;

  assign counting   = (state_q == pwm_cap_pkg::CH_COUNT) & ~stop_trig
                    & unit_on;
  assign do_start   = (state_q == pwm_cap_pkg::CH_WAIT_START) & start_edge
                    & ~stop_trig & unit_on;
  assign do_capture = counting & capt_edge;

  width_counter #(
    .W (CNT_W)
  ) u_cnt (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clear_i   (do_start),
    .clr_all_i (~unit_on),
    .run_i     (counting & ~capt_edge),
    .count_o   (count),
    .wrapped_o (wrapped)
  );

  // ***************************************************************
  // capture, overflow flag
  // ***************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      capture_data_q          <= pwm_cap_pkg::CNT_ZERO;
      counter_overflow_flag_q <= 1'b0;
    end else if (!unit_on) begin
      capture_data_q          <= pwm_cap_pkg::CNT_ZERO;
      counter_overflow_flag_q <= 1'b0;
    end else if (do_capture) begin
      capture_data_q          <= count;
      counter_overflow_flag_q <= wrapped;
    end
  end

  // ***************************************************************
  // interrupt status and mask
  // ***************************************************************
  logic irq_clr;

  assign irq_clr = wr & (wb_adr_i == pwm_cap_pkg::IRQS_OFF) & wb_sel_i[0]
                 & wb_dat_i[pwm_cap_pkg::IRQ_CAPT_BIT];

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= 1'b0;
    end else if (!unit_on) begin
      irq_stat_q <= 1'b0;
    end else if (do_capture) begin
      irq_stat_q <= 1'b1;
    end else if (irq_clr) begin
      irq_stat_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= 1'b0;
    end else if (!unit_on) begin
      irq_mask_q <= 1'b0;
    end else if (wr && wb_adr_i == pwm_cap_pkg::IRQM_OFF && wb_sel_i[0]) begin
      irq_mask_q <= wb_dat_i[pwm_cap_pkg::IRQ_CAPT_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_o <= 1'b0;
    end else begin
      // next-state view, so the line drops in the same cycle as the status clear
      irq_o <= unit_on & irq_mask_q
               & (do_capture | (irq_stat_q & ~irq_clr));
    end
  end

  // ***************************************************************
  // read mux and acknowledge
  // ***************************************************************
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      pwm_cap_pkg::PER_OFF:  rdata[pwm_cap_pkg::UNIT_EN_BIT] =
                               unit_clock_enable_q;
      pwm_cap_pkg::MODE_OFF: begin
        rdata[pwm_cap_pkg::NF_BIT] = noise_filter_enable_q;
        rdata[pwm_cap_pkg::EDGE_HI:pwm_cap_pkg::EDGE_LO] = edge_sel_q;
      end
      pwm_cap_pkg::EN_OFF:   rdata[0] = channel_enable_status_q;
      pwm_cap_pkg::CNT_OFF:  rdata[CNT_W-1:0] = count;
      pwm_cap_pkg::DATA_OFF: rdata[CNT_W-1:0] = capture_data_q;
      pwm_cap_pkg::STAT_OFF: rdata[pwm_cap_pkg::OVF_BIT] =
                               counter_overflow_flag_q;
      pwm_cap_pkg::IRQS_OFF: rdata[0] = irq_stat_q;
      pwm_cap_pkg::IRQM_OFF: rdata[0] = irq_mask_q;
      pwm_cap_pkg::OUTC_OFF: rdata[2:0] = out_ctrl_q;
      default:               rdata = 32'h0000_0000;
    endcase
    if (!unit_on && wb_adr_i != pwm_cap_pkg::PER_OFF) begin
      rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? (rdata & {32{1'b1}}) : 32'h0000_0000;
    end
  end

  logic unused_mask;
  assign unused_mask = ^wmask;

endmodule : pulse_width_capture_channel

`default_nettype wire

// ---- pulse_source.sv ----
`timescale 1ns/1ps
`default_nettype none

module pulse_source (
  // clock
  input  wire logic core_clk,
  // measured pin
  output var  logic pin_o
);
  initial pin_o = 1'b0;

  // level changes only just after a rising edge
  task automatic drive(input logic v);
    @(posedge core_clk);
    pin_o <= v;
  endtask : drive
endmodule : pulse_source

`default_nettype wire

// ---- pulse_width_capture_channel_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module pwc_checker #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // pin and interrupt
  input  wire logic        timer_input_pin,
  input  wire logic        irq_o
);
  logic rq;
  logic rd;
  logic unit_on_q;

  assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = rq && !wb_we_i;

  // unit enable as last written by software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      unit_on_q <= 1'b0;
    end else if (rq && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == pwm_cap_pkg::PER_OFF) begin
      unit_on_q <= wb_dat_i[0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_after_req: assert property (rq |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_trig_reads_zero: assert property (
    rd && wb_adr_i == pwm_cap_pkg::TRIG_OFF |=> wb_dat_o == 32'h0)
    else $error("trigger bits read back set");
  a_off_reads_zero: assert property (
    rd && !unit_on_q && wb_adr_i != pwm_cap_pkg::PER_OFF
    |=> wb_dat_o == 32'h0)
    else $error("register nonzero while unit off");
  a_irq_off_unit: assert property (
    !unit_on_q && $past(!unit_on_q) |-> !irq_o)
    else $error("interrupt while unit off");
  a_irq_fall_write: assert property (
    $fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("interrupt dropped without a write");
  a_count_width: assert property (
    rd && (wb_adr_i == pwm_cap_pkg::CNT_OFF
           || wb_adr_i == pwm_cap_pkg::DATA_OFF)
    |=> wb_dat_o[31:16] == 16'h0)
    else $error("count wider than 16 bits");
endmodule : pwc_checker

bind pulse_width_capture_channel pwc_checker #(.CNT_W(CNT_W)) u_chk (
  .core_clk        (core_clk),
  .resetn          (resetn),
  .wb_cyc_i        (wb_cyc_i),
  .wb_stb_i        (wb_stb_i),
  .wb_we_i         (wb_we_i),
  .wb_adr_i        (wb_adr_i),
  .wb_sel_i        (wb_sel_i),
  .wb_dat_i        (wb_dat_i),
  .wb_dat_o        (wb_dat_o),
  .wb_ack_o        (wb_ack_o),
  .timer_input_pin (timer_input_pin),
  .irq_o           (irq_o)
);

`default_nettype wire

// ---- pulse_width_capture_channel_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module pulse_width_capture_channel_tb;
  logic        core_clk  = 1'b0;
  logic        resetn    = 1'b0;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin;
  logic        irq_o;
  logic [31:0] q;
  logic [31:0] c;
  int          cyc_n     = 0;
  int          bad_count = 0;
  int          compares  = 0;

  always #4 core_clk = ~core_clk;

  pulse_source src (.core_clk(core_clk), .pin_o(pin));

  pulse_width_capture_channel dut (
    .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_input_pin(pin), .irq_o(irq_o));

  task automatic conclude;
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000) begin
      bad_count++;
      conclude;
    end
  end

  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", n, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask : rc

  // one measured pulse; w of 0 pokes the start trigger mid-pulse
  task automatic meas(input logic lvl, input int w, input logic ovf,
                      input logic irq);
    int t0;
    src.drive(lvl);
    t0 = cyc_n;
    if (w == 0) wr(pwm_cap_pkg::TRIG_OFF, 32'h1);
    else repeat (w - 1) @(posedge core_clk);
    src.drive(!lvl);
    t0 = cyc_n - t0 - 1;
    q = 32'h0;
    for (int k = 0; k < 8 && q[0] !== 1'b1; k++)
      bus(1'b0, pwm_cap_pkg::IRQS_OFF, 32'h0);
    rc("data", pwm_cap_pkg::DATA_OFF, {16'h0, t0[15:0]});
    rc("ovf", pwm_cap_pkg::STAT_OFF, {31'h0, ovf});
    chk("irq", {31'h0, irq_o}, {31'h0, irq});
    wr(pwm_cap_pkg::IRQS_OFF, 32'h1);
    rc("irqs", pwm_cap_pkg::IRQS_OFF, 32'h0);
  endtask : meas

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    wr(pwm_cap_pkg::MODE_OFF, 32'h201);
    rc("mode_off", pwm_cap_pkg::MODE_OFF, 32'h0);
    wr(pwm_cap_pkg::PER_OFF, 32'h1);
    rc("mode_rst", pwm_cap_pkg::MODE_OFF, 32'h300);
    rc("unmapped", 8'h40, 32'h0);
    wr(pwm_cap_pkg::IRQM_OFF, 32'h1);
    wr(pwm_cap_pkg::OUTC_OFF, 32'h0);
    wr(pwm_cap_pkg::MODE_OFF, 32'h301);
    wr(pwm_cap_pkg::TRIG_OFF, 32'h1);
    rc("en", pwm_cap_pkg::EN_OFF, 32'h1);
    rc("trig", pwm_cap_pkg::TRIG_OFF, 32'h0);
    meas(1'b1, 5, 1'b0, 1'b1);
    meas(1'b1, 0, 1'b0, 1'b1);
    wr(pwm_cap_pkg::IRQM_OFF, 32'h0);
    wr(pwm_cap_pkg::MODE_OFF, 32'h201);
    src.drive(1'b1);
    meas(1'b0, 3, 1'b0, 1'b0);
    wr(pwm_cap_pkg::IRQM_OFF, 32'h1);
    wr(pwm_cap_pkg::MODE_OFF, 32'h301);
    src.drive(1'b0);
    meas(1'b1, 65537, 1'b1, 1'b1);
    src.drive(1'b1);
    repeat (20) @(posedge core_clk);
    wr(pwm_cap_pkg::TRIG_OFF, 32'h2);
    rc("en_stop", pwm_cap_pkg::EN_OFF, 32'h0);
    bus(1'b0, pwm_cap_pkg::CNT_OFF, 32'h0);
    c = q;
    chk("cnt_stop", c, 32'h14);
    rc("cnt_hold", pwm_cap_pkg::CNT_OFF, c);
    rc("ovf_hold", pwm_cap_pkg::STAT_OFF, 32'h1);
    src.drive(1'b0);
    rc("no_capt", pwm_cap_pkg::IRQS_OFF, 32'h0);
    rc("cnt_hold2", pwm_cap_pkg::CNT_OFF, c);
    wr(pwm_cap_pkg::OUTC_OFF, 32'h5);
    rc("outc", pwm_cap_pkg::OUTC_OFF, 32'h5);
    wr(pwm_cap_pkg::OUTC_OFF, 32'h0);
    wr(pwm_cap_pkg::TRIG_OFF, 32'h1);
    meas(1'b1, 4, 1'b0, 1'b1);
    src.drive(1'b1);
    src.drive(1'b0);
    rc("irqs_set", pwm_cap_pkg::IRQS_OFF, 32'h1);
    wr(pwm_cap_pkg::PER_OFF, 32'h0);
    wr(pwm_cap_pkg::PER_OFF, 32'h1);
    rc("irqs_init", pwm_cap_pkg::IRQS_OFF, 32'h0);
    chk("irq_init", {31'h0, irq_o}, 32'h0);
    rc("en_init", pwm_cap_pkg::EN_OFF, 32'h0);
    rc("data_init", pwm_cap_pkg::DATA_OFF, 32'h0);
    rc("mode_init", pwm_cap_pkg::MODE_OFF, 32'h300);
    conclude;
  end
endmodule : pulse_width_capture_channel_tb

`default_nettype wire
